// ===== inc/vor_map.svh
// constants for the video output reference control block
// assumes it is included by both ends and by the package users
// Operation
// - qualifier starts at programmed begin position
// - host writes only even begin positions
// - qualifier ends at programmed end position
// - host writes only even end positions
// - programmed window only when control bit set
// - mode clear: window from current window size
// - line reference polarity from bit one
// - field sync polarity from bit two
// - field sync width is code plus two
// - odd/even pin released when disable bit set
// - port B shows static bits when programmable
// - static bits only with double clock mode
// - parallel or byte-serial pixel word routing
// - vbi qualifier routed to active or test pin
// - host writes zero to reserved routing bit
// - keep programmed frames out of 3000
// - new frame count applied by latch flag
// - three-bit code names eight tv standards
// - codes 0,2,5 mean 625 lines else 525
// - host polls busy before address and data
`ifndef VOR_MAP_SVH
`define VOR_MAP_SVH
// ****************************************
// parameter memory locations
// ****************************************
`define VOR_LOC_CTRL 12'h140
`define VOR_LOC_BEGIN 12'h151
`define VOR_LOC_END 12'h152
`define VOR_LOC_SYNC 12'h153
`define VOR_LOC_ROUTE 12'h154
`define VOR_LOC_DECIM 12'h157
// ****************************************
// reset values and fields
// ****************************************
`define VOR_RST_BEGIN 12'h028
`define VOR_RST_END 12'h2d0
`define VOR_RST_SYNC 12'h000
`define VOR_RST_ROUTE 12'h000
`define VOR_RST_DECIM 12'hbb8
`define VOR_RST_CTRL 12'h000
`define VOR_DECIM_BASE 13'h0bb8
`define VOR_CTRL_PMODE 2
`define VOR_CTRL_LATCH 10
`define VOR_SYNC_HPOL 1
`define VOR_SYNC_VPOL 2
`define VOR_SYNC_VLEN 5:3
`define VOR_SYNC_DISF 6
`define VOR_RT_BITS 7:0
`define VOR_RT_BMPON 8
`define VOR_RT_DOUBLE 9
`define VOR_RT_VBI 10
`define VOR_RT_RSVD 11
`define VOR_POS 10:0
// ****************************************
// frame geometry
// ****************************************
`define VOR_LINES_50 10'd625
`define VOR_LINES_60 10'd525
`define VOR_VLEN_OFS 4'd2
// ****************************************
// link subaddresses and timing
// ****************************************
`define VOR_SUB_BUSY 8'h35
`define VOR_SUB_ADDR 8'h37
`define VOR_SUB_DATA 8'h38
`define VOR_BUSY_BIT 2
`define VOR_BUSY_CYC 4'h4
// ****************************************
// host apb map
// ****************************************
`define VOR_APB_TARGET 8'h00
`define VOR_APB_WDATA 8'h04
`define VOR_APB_STATUS 8'h08
`define VOR_APB_PIXEL 8'h0c
`endif

// ===== inc/vor_pkg.sv
// types shared by both ends of the video output reference link
// assumes vor_map.svh supplies the numeric constants other than the enum encodings defined here
package vor_pkg;
    // tv standard codes
    typedef enum logic [2:0] {
        STD_PAL = 3'h0, STD_NTSC = 3'h1, STD_SECAM = 3'h2, STD_NTSC44 = 3'h3,
        STD_PALM = 3'h4, STD_PALN = 3'h5, STD_PAL60 = 3'h6, STD_NTSCC = 3'h7
    } vor_std_t;
    // host link sequencer states
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_POLL = 5'h02,
        H_POLLWT = 5'h04,
        H_WRITE = 5'h08,
        H_WRWT = 5'h10
    } vor_hstate_t;
endpackage : vor_pkg

// ===== inc/vor_link_if.sv
// control link and pixel pins between decoder output stage and host
// assumes both ends share one clock; the bench resolves enables
interface vor_link_if;
    // control link
    logic [7:0] subAddr;
    logic [15:0] wrData;
    logic wrStb;
    logic rdStb;
    logic [15:0] rdData;
    logic ack;
    // pixel and reference pins
    logic [7:0] portA;
    logic [7:0] portB;
    logic portBOe;
    logic lineRef;
    logic fieldSync;
    logic oddEven;
    logic oddEvenOe;
    logic actVideo;
    logic testData;
    modport dev (
        input subAddr, wrData, wrStb, rdStb,
        output rdData, ack, portA, portB, portBOe, lineRef, fieldSync,
        output oddEven, oddEvenOe, actVideo, testData
    );
    modport host (
        output subAddr, wrData, wrStb, rdStb,
        input rdData, ack, portA, portB, portBOe, lineRef, fieldSync,
        input oddEven, oddEvenOe, actVideo, testData
    );
endinterface : vor_link_if

// ===== logic/vor_line_timer.sv
// pixel and line counters for one video frame
// assumes one pixel per clock and a standard code from the user
`include "vor_map.svh"
module vor_line_timer #(
    parameter int LINE_LEN = 864,
    parameter int REF_LEN = 144
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // standard
    input wire logic [2:0] stdCode,
    // timing
    output logic [10:0] pixPos,
    output logic refAct,
    output logic lineStart,
    output logic fieldStart,
    output logic frameStart,
    output logic secondField
);
    logic [10:0] pixCnt_q;
    logic [9:0] lineCnt_q;
    logic [9:0] lines;
    logic [9:0] half;
    logic lastPix;

    // lines per frame from the standard
    always_comb begin
        unique case (vor_pkg::vor_std_t'(stdCode))
            vor_pkg::STD_PAL, vor_pkg::STD_SECAM, vor_pkg::STD_PALN: begin
                lines = `VOR_LINES_50;
            end
            default: begin
                lines = `VOR_LINES_60;
            end
        endcase
        half = 10'((lines + 10'd1) >> 1);
    end

    assign lastPix = pixCnt_q == 11'(LINE_LEN - 1);

    // pixel counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pixCnt_q <= 11'h0;
        else pixCnt_q <= lastPix ? 11'h0 : pixCnt_q + 11'h1;
    end

    // line counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineCnt_q <= 10'h0;
        end else if (lastPix) begin
            lineCnt_q <= (lineCnt_q >= lines - 10'h1) ? 10'h0 : lineCnt_q + 10'h1;
        end
    end

    assign refAct = pixCnt_q < 11'(REF_LEN);
    assign pixPos = pixCnt_q - 11'(REF_LEN);
    assign lineStart = pixCnt_q == 11'h0;
    assign frameStart = lineStart && lineCnt_q == 10'h0;
    assign fieldStart = lineStart && (lineCnt_q == 10'h0 || lineCnt_q == half);
    assign secondField = lineCnt_q >= half;
endmodule : vor_line_timer

// ===== logic/vor_device.sv
// decoder back-end output stage: parameter memory and reference pins
// assumes host keeps the busy handshake and one pixel per clock
//
// The APB register port is this design's own decision.
`include "vor_map.svh"
module vor_device #(
    parameter int LINE_LEN = 864,
    parameter int REF_LEN = 144
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to host
    vor_link_if.dev link,
    // processed pixel bus and source state
    input wire logic [15:0] pixelWord,
    input wire logic [2:0] stdCode,
    input wire logic [10:0] windowSize,
    input wire logic vbiActive,
    // frame decimation status
    output logic frameShown
);
    // ****************************************
    // parameter memory
    // ****************************************
    logic [11:0] ctrl_q;
    logic [11:0] begin_q;
    logic [11:0] end_q;
    logic [11:0] sync_q;
    logic [11:0] route_q;
    logic [11:0] decimPend_q;
    logic [11:0] decimAct_q;
    logic [11:0] memAddr_q;
    logic [3:0] busyCnt_q;
    logic busy;
    logic memWr;
    logic [11:0] memData;

    assign busy = busyCnt_q != 4'h0;
    assign memData = link.wrData[11:0];
    assign memWr = link.wrStb && !busy && link.subAddr == `VOR_SUB_DATA;

    // address register of the memory port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memAddr_q <= 12'h0;
        end else if (link.wrStb && !busy && link.subAddr == `VOR_SUB_ADDR) begin
            memAddr_q <= link.wrData[11:0];
        end
    end

    // busy timer after each address or data write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt_q <= 4'h0;
        end else if (link.wrStb && !busy) begin
            busyCnt_q <= `VOR_BUSY_CYC;
        end else if (busy) begin
            busyCnt_q <= busyCnt_q - 4'h1;
        end
    end

    // acknowledge and read answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.ack <= 1'b0;
            link.rdData <= 16'h0;
        end else begin
            link.ack <= link.wrStb || link.rdStb;
            if (link.rdStb) begin
                link.rdData <= 16'h0;
                if (link.subAddr == `VOR_SUB_BUSY) link.rdData[`VOR_BUSY_BIT] <= busy;
            end
        end
    end

    // memory locations
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `VOR_RST_CTRL;
            begin_q <= `VOR_RST_BEGIN;
            end_q <= `VOR_RST_END;
            sync_q <= `VOR_RST_SYNC;
            route_q <= `VOR_RST_ROUTE;
            decimPend_q <= `VOR_RST_DECIM;
        end else if (memWr) begin
            unique case (memAddr_q)
                `VOR_LOC_CTRL: ctrl_q <= memData;
                `VOR_LOC_BEGIN: begin_q <= memData;
                `VOR_LOC_END: end_q <= memData;
                `VOR_LOC_SYNC: sync_q <= memData;
                `VOR_LOC_ROUTE: route_q <= memData;
                `VOR_LOC_DECIM: decimPend_q <= memData;
                default: ;
            endcase
        end
    end

    // active frame count follows the latch flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            decimAct_q <= `VOR_RST_DECIM;
        end else if (memWr && memAddr_q == `VOR_LOC_CTRL && memData[`VOR_CTRL_LATCH]) begin
            decimAct_q <= decimPend_q;
        end else if (memWr && memAddr_q == `VOR_LOC_DECIM && ctrl_q[`VOR_CTRL_LATCH]) begin
            decimAct_q <= memData;
        end
    end

    // ****************************************
    // timing
    // ****************************************
    logic [10:0] pixPos;
    logic refAct;
    logic lineStart;
    logic fieldStart;
    logic frameStart;
    logic secondField;

    vor_line_timer #(
        .LINE_LEN(LINE_LEN),
        .REF_LEN(REF_LEN)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .stdCode(stdCode),
        .pixPos(pixPos),
        .refAct(refAct),
        .lineStart(lineStart),
        .fieldStart(fieldStart),
        .frameStart(frameStart),
        .secondField(secondField)
    );

    // ****************************************
    // temporal decimation
    // ****************************************
    logic [12:0] acc_q;
    logic [12:0] accSum;
    logic show_q;

    assign accSum = acc_q + {1'b0, decimAct_q};

    // keep frames as the accumulator passes the base
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 13'h0;
            show_q <= 1'b1;
        end else if (frameStart) begin
            if (accSum >= `VOR_DECIM_BASE) begin
                acc_q <= accSum - `VOR_DECIM_BASE;
                show_q <= 1'b1;
            end else begin
                acc_q <= accSum;
                show_q <= 1'b0;
            end
        end
    end

    assign frameShown = show_q;

    // ****************************************
    // field sync width
    // ****************************************
    logic [3:0] vsCnt_q;

    // width counted in whole lines from field start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vsCnt_q <= 4'h0;
        end else if (fieldStart) begin
            vsCnt_q <= {1'b0, sync_q[`VOR_SYNC_VLEN]} + `VOR_VLEN_OFS;
        end else if (lineStart && vsCnt_q != 4'h0) begin
            vsCnt_q <= vsCnt_q - 4'h1;
        end
    end

    // ****************************************
    // active video qualifier
    // ****************************************
    logic inWindow;

    // window choice by the qualifier mode bit
    always_comb begin
        if (ctrl_q[`VOR_CTRL_PMODE]) begin
            inWindow = pixPos >= begin_q[`VOR_POS] && pixPos < end_q[`VOR_POS];
        end else begin
            inWindow = pixPos < windowSize;
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    logic act;
    logic phase_q;
    logic [7:0] lowByte_q;

    assign act = inWindow && !refAct && show_q;

    // reference pins with polarity
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.lineRef <= 1'b0;
            link.fieldSync <= 1'b0;
            link.oddEven <= 1'b0;
            link.oddEvenOe <= 1'b1;
            link.actVideo <= 1'b0;
            link.testData <= 1'b0;
        end else begin
            link.lineRef <= refAct ^ sync_q[`VOR_SYNC_HPOL];
            link.fieldSync <= (vsCnt_q != 4'h0) ^ sync_q[`VOR_SYNC_VPOL];
            link.oddEven <= secondField;
            link.oddEvenOe <= !sync_q[`VOR_SYNC_DISF];
            if (route_q[`VOR_RT_VBI]) begin
                link.actVideo <= act;
                link.testData <= vbiActive;
            end else begin
                link.actVideo <= act || vbiActive;
                link.testData <= 1'b0;
            end
        end
    end

    // byte phase for double clock mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) phase_q <= 1'b0;
        else phase_q <= route_q[`VOR_RT_DOUBLE] && !phase_q;
    end

    // pixel ports
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.portA <= 8'h0;
            link.portB <= 8'h0;
            link.portBOe <= 1'b1;
            lowByte_q <= 8'h0;
        end else if (!route_q[`VOR_RT_DOUBLE]) begin
            link.portA <= pixelWord[15:8];
            link.portB <= pixelWord[7:0];
            link.portBOe <= 1'b1;
        end else begin
            if (!phase_q) begin
                link.portA <= pixelWord[15:8];
                lowByte_q <= pixelWord[7:0];
            end else begin
                link.portA <= lowByte_q;
            end
            link.portB <= route_q[`VOR_RT_BITS];
            link.portBOe <= route_q[`VOR_RT_BMPON];
        end
    end
endmodule : vor_device

// ===== logic/vor_host.sv
// host end: apb registers, parameter memory writer, pin sampler
// assumes apb master on the same clock; link device answers with ack
`include "vor_map.svh"
module vor_host (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to device
    vor_link_if.host link
);
    vor_pkg::vor_hstate_t st_q;
    logic [11:0] target_q;
    logic [11:0] data_q;
    logic second_q;
    logic [15:0] pixel_q;
    logic setup;
    logic start;
    logic mapped;
    logic [11:0] clean;

    assign setup = psel && !penable;
    assign pready = 1'b1;
    assign mapped = paddr == `VOR_APB_TARGET || paddr == `VOR_APB_WDATA
        || paddr == `VOR_APB_STATUS || paddr == `VOR_APB_PIXEL;
    assign pslverr = psel && penable && !mapped;
    assign start = psel && penable && pwrite && paddr == `VOR_APB_WDATA
        && st_q == vor_pkg::H_IDLE;

    // data cleaned of illegal values before sending
    always_comb begin
        clean = pwdata[11:0];
        if (target_q == `VOR_LOC_BEGIN || target_q == `VOR_LOC_END) clean[0] = 1'b0;
        if (target_q == `VOR_LOC_ROUTE) begin
            clean[`VOR_RT_RSVD] = 1'b0;
            if (!clean[`VOR_RT_DOUBLE]) clean[`VOR_RT_BMPON] = 1'b0;
        end
    end

    // apb registers and read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            target_q <= 12'h0;
            data_q <= 12'h0;
            prdata <= 32'h0;
        end else begin
            if (psel && penable && pwrite && paddr == `VOR_APB_TARGET) target_q <= pwdata[11:0];
            if (start) data_q <= clean;
            if (setup) begin
                unique case (paddr)
                    `VOR_APB_TARGET: prdata <= {20'h0, target_q};
                    `VOR_APB_WDATA: prdata <= {20'h0, data_q};
                    `VOR_APB_STATUS: prdata <= {27'h0, link.oddEven, link.fieldSync,
                        link.actVideo, link.lineRef, st_q != vor_pkg::H_IDLE};
                    `VOR_APB_PIXEL: prdata <= {16'h0, pixel_q};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // pixel port sampler
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pixel_q <= 16'h0;
        else pixel_q <= {link.portA, link.portBOe ? link.portB : 8'h0};
    end

    // poll busy, write address, poll busy, write data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= vor_pkg::H_IDLE;
            second_q <= 1'b0;
        end else begin
            unique case (st_q)
                vor_pkg::H_IDLE: if (start) begin
                    st_q <= vor_pkg::H_POLL;
                    second_q <= 1'b0;
                end
                vor_pkg::H_POLL: st_q <= vor_pkg::H_POLLWT;
                vor_pkg::H_POLLWT: if (link.ack) begin
                    st_q <= link.rdData[`VOR_BUSY_BIT] ? vor_pkg::H_POLL : vor_pkg::H_WRITE;
                end
                vor_pkg::H_WRITE: st_q <= vor_pkg::H_WRWT;
                vor_pkg::H_WRWT: if (link.ack) begin
                    st_q <= second_q ? vor_pkg::H_IDLE : vor_pkg::H_POLL;
                    second_q <= 1'b1;
                end
            endcase
        end
    end

    // link strobes
    always_comb begin
        link.rdStb = st_q == vor_pkg::H_POLL;
        link.wrStb = st_q == vor_pkg::H_WRITE;
        link.subAddr = `VOR_SUB_BUSY;
        link.wrData = 16'h0;
        if (st_q == vor_pkg::H_WRITE) begin
            link.subAddr = second_q ? `VOR_SUB_DATA : `VOR_SUB_ADDR;
            link.wrData = {4'h0, second_q ? data_q : target_q};
        end
    end
endmodule : vor_host

// ===== test/vor_link_monitor.sv
// checker for the control link and port pins between the two ends
// assumes it sees the interface signals directly, one clock domain
`include "vor_map.svh"
module vor_link_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control link
    input wire logic [7:0] subAddr,
    input wire logic [15:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [15:0] rdData,
    input wire logic ack,
    // pins
    input wire logic [7:0] portB,
    input wire logic portBOe,
    input wire logic oddEvenOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] addr_q, route_q, sync_q;
    logic rdPend_q, pollOk_q;
    logic dataWr;
    logic posWr;
    // ****************************************
    // shadow of parameter memory writes
    // ****************************************
    assign dataWr = wrStb && subAddr == `VOR_SUB_DATA;
    assign posWr = dataWr && (addr_q == `VOR_LOC_BEGIN || addr_q == `VOR_LOC_END);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= 12'h000;
            route_q <= `VOR_RST_ROUTE;
            sync_q <= `VOR_RST_SYNC;
        end else if (wrStb && subAddr == `VOR_SUB_ADDR) begin
            addr_q <= wrData[11:0];
        end else if (dataWr && addr_q == `VOR_LOC_ROUTE) begin
            route_q <= wrData[11:0];
        end else if (dataWr && addr_q == `VOR_LOC_SYNC) begin
            sync_q <= wrData[11:0];
        end
    end
    // last busy poll answered clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdPend_q <= 1'b0;
            pollOk_q <= 1'b0;
        end else begin
            rdPend_q <= rdStb ? (subAddr == `VOR_SUB_BUSY) : (rdPend_q && !ack);
            if (wrStb) begin
                pollOk_q <= 1'b0;
            end else if (rdPend_q && ack) begin
                pollOk_q <= !rdData[`VOR_BUSY_BIT];
            end
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_ackPulse;
        ack ##1 !ack;
    endsequence
    AST_LINK_ACK: assert property ((wrStb || rdStb) |-> ##[1:2] s_ackPulse)
        else $error("strobe not answered by a one cycle ack");
    AST_ONE_STROBE: assert property ((wrStb || rdStb) |=> !(wrStb || rdStb))
        else $error("strobes back to back");
    AST_POLL_FIRST: assert property (wrStb |-> pollOk_q)
        else $error("link write without a clear busy poll");
    AST_EVEN_POS: assert property (posWr |-> !wrData[0])
        else $error("odd window position written");
    AST_RSVD_ZERO: assert property (dataWr && addr_q == `VOR_LOC_ROUTE |->
        !wrData[11] && !(wrData[8] && !wrData[9]))
        else $error("routing word with reserved or unpaired bits");
    AST_PORTB_STATIC: assert property ((route_q[9] && route_q[8] && $stable(route_q))[*3]
        |-> portB == route_q[7:0] && portBOe)
        else $error("port B not showing static bits");
    AST_PORTB_IDLE: assert property ((route_q[9] && !route_q[8] && $stable(route_q))[*3]
        |-> !portBOe)
        else $error("port B driven while unused");
    AST_PORTB_DRIVEN: assert property ((!route_q[9] && $stable(route_q))[*3]
        |-> portBOe)
        else $error("port B released in single clock mode");
    AST_FIELD_OFF: assert property ((sync_q[6] && $stable(sync_q))[*3] |-> !oddEvenOe)
        else $error("odd even pin driven while disabled");
    AST_FIELD_ON: assert property ((!sync_q[6] && $stable(sync_q))[*3] |-> oddEvenOe)
        else $error("odd even pin released while enabled");
endmodule : vor_link_monitor

// ===== test/vor_tb.sv
// self-checking bench: apb host end facing the device end over the link
// assumes short lines (32 pixels, 8 reference) to keep frames brief
`include "vor_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LL = 32;
    localparam int RL = 8;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, vbiActive, frameShown, e;
    logic [7:0] paddr, a0, a1;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] pixelWord;
    logic [2:0] stdCode;
    logic [10:0] windowSize;
    int error_cnt = 0;
    int cmp_count = 0;
    int nr, na, nt;
    vor_link_if link();
    vor_device #(.LINE_LEN(LL), .REF_LEN(RL)) i_vor_device (.clk(clk), .reset_n(reset_n),
        .link(link), .pixelWord(pixelWord), .stdCode(stdCode), .windowSize(windowSize),
        .vbiActive(vbiActive), .frameShown(frameShown));
    vor_host i_vor_host (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    vor_link_monitor i_vor_link_monitor (.clk(clk), .reset_n(reset_n),
        .subAddr(link.subAddr), .wrData(link.wrData), .wrStb(link.wrStb),
        .rdStb(link.rdStb), .rdData(link.rdData), .ack(link.ack), .portB(link.portB),
        .portBOe(link.portBOe), .oddEvenOe(link.oddEvenOe));
    // clock
    always #12.5 clk = ~clk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // parameter memory write, then wait for busy to clear
    task automatic cfg(input logic [11:0] loc, input logic [11:0] val);
        int n;
        n = 0;
        apb(1'b1, `VOR_APB_TARGET, {20'h0, loc});
        apb(1'b1, `VOR_APB_WDATA, {20'h0, val});
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 50) begin
            apb(1'b0, `VOR_APB_STATUS, 32'h0);
            n++;
        end
        chk(r[0], 1'b0);
        repeat (3) @(posedge clk);
    endtask : cfg
    // active cycles of reference, qualifier and test pin over one line
    task automatic lineCnt();
        nr = 0;
        na = 0;
        nt = 0;
        @(posedge clk);
        repeat (LL) begin
            @(negedge clk);
            nr += int'(link.lineRef === 1'b1);
            na += int'(link.actVideo === 1'b1);
            nt += int'(link.testData === 1'b1);
        end
    endtask : lineCnt
    // field sync pulse length and frame length from one active edge
    task automatic fieldMeas(input logic pol, input int expRun, input int expFrame);
        logic prev, cur;
        int n, run, rises;
        prev = 1'b1;
        cur = 1'b1;
        n = 0;
        while (!(cur && !prev) && n < 30000) begin
            @(negedge clk);
            prev = cur;
            cur = link.fieldSync ^ pol;
            n++;
        end
        n = 1;
        run = 1;
        rises = 0;
        while (rises < 2 && n < 30000) begin
            @(negedge clk);
            prev = cur;
            cur = link.fieldSync ^ pol;
            if (cur && !prev) rises++;
            if (rises < 2) n++;
            if (cur && rises == 0) run++;
        end
        chk(run, expRun);
        chk(n, expFrame);
    endtask : fieldMeas
    // watchdog
    initial begin
        repeat (99000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pixelWord = 16'hc35a;
        stdCode = vor_pkg::STD_PAL;
        windowSize = 11'h010;
        vbiActive = 1'b0;
        repeat (2) @(posedge clk);
        chk({link.portBOe, link.oddEvenOe, frameShown}, 32'h7);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({link.portA, link.portB}, 32'hc35a);
        apb(1'b0, 8'h10, 32'h0);
        chk(e, 1'b1);
        cfg(`VOR_LOC_ROUTE, 12'h1ff);
        chk({link.portA, link.portB}, 32'hc35a);
        cfg(`VOR_LOC_ROUTE, 12'h3a5);
        chk({link.portB, link.portBOe}, 32'h14b);
        a0 = link.portA;
        @(posedge clk);
        a1 = link.portA;
        chk({a0, a1} == 16'hc35a || {a0, a1} == 16'h5ac3, 1'b1);
        cfg(`VOR_LOC_ROUTE, 12'h200);
        chk(link.portBOe, 1'b0);
        lineCnt();
        chk(nr, RL);
        cfg(`VOR_LOC_SYNC, 12'h042);
        lineCnt();
        chk(nr, LL - RL);
        chk(link.oddEvenOe, 1'b0);
        cfg(`VOR_LOC_ROUTE, 12'h000);
        cfg(`VOR_LOC_BEGIN, 12'h004);
        cfg(`VOR_LOC_END, 12'h00a);
        cfg(`VOR_LOC_CTRL, 12'h004);
        lineCnt();
        chk(na, 6);
        @(posedge clk);
        vbiActive <= 1'b1;
        lineCnt();
        chk(na, LL);
        cfg(`VOR_LOC_ROUTE, 12'h400);
        lineCnt();
        chk(na, 6);
        chk(nt, LL);
        @(posedge clk);
        vbiActive <= 1'b0;
        cfg(`VOR_LOC_DECIM, 12'h000);
        cfg(`VOR_LOC_SYNC, 12'h03c);
        fieldMeas(1'b1, 9 * LL, 625 * LL);
        chk(frameShown, 1'b1);
        @(posedge clk);
        stdCode <= vor_pkg::STD_NTSC;
        cfg(`VOR_LOC_CTRL, 12'h404);
        cfg(`VOR_LOC_SYNC, 12'h000);
        fieldMeas(1'b0, 2 * LL, 525 * LL);
        chk(frameShown, 1'b0);
        conclude();
    end
endmodule : tb
